// *** bench/network_wake_event_detector_tb.sv ***
// Self-checking bench for the wake event logic
`timescale 1ns/1ps
`include "wake_regs.svh"
module network_wake_event_detector_tb;
	// ==========================================
	// Signals
	logic               clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic               link_up_pin, bus_reset_n, eeprom_addr_load, rx_store_en;
	logic               inta_n, power_event_pin_n, external_start_n, network_wake_out;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, m, seed;
	logic [47:0]        eeprom_addr, node;
	logic [15:0]        crc_ref;
	logic [32:0]        e;
	logic [32:0]        exp_q[$];
	logic [7:0]         fr[$];
	wake_pkg::rx_beat_t rx_beat;
	int                 num_errors, num_checks;

	network_wake_event_detector dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_beat(rx_beat), .link_up_pin(link_up_pin),
		.bus_reset_n(bus_reset_n), .eeprom_addr_load(eeprom_addr_load),
		.eeprom_addr(eeprom_addr), .inta_n(inta_n), .power_event_pin_n(power_event_pin_n),
		.external_start_n(external_start_n), .network_wake_out(network_wake_out),
		.rx_store_en(rx_store_en));
	rx_frame_source src (.clk(clk), .rx_beat(rx_beat));

	// Clock, 5 ns period
	always #2.5 clk = ~clk;

	// ==========================================
	// Helpers
	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : nxt
	// Data bits enter LSB first into a left-shifting register
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CRC_POLY : 16'h0000);
		return c;
	endfunction : crc_byte
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One APB transfer; the expectation is queued for the monitor
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
		int n;
		exp_q.push_back(x);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Look at ready mid-cycle, where it has settled, then release on the next edge
		do
		begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			num_errors++;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, {1'b0, x});
	endtask : rd
	// Six filler bytes, sync run, sixteen node address copies, then filler; byte k of node is bits 8k+7:8k
	task pattern_frame();
		fr = {};
		for (int i = 0; i < 6; i++) fr.push_back(8'(nxt()));
		for (int i = 0; i < 6; i++) fr.push_back(`SYNC_BYTE);
		for (int i = 0; i < 96; i++) fr.push_back(node[8 * (i % 6) +: 8]);
		for (int i = 0; i < 4; i++) fr.push_back(8'(nxt()));
	endtask : pattern_frame
	task close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// Monitor: each completed transfer is matched with the oldest note, mid-cycle
	always @(negedge clk)
		if (psel && penable && pready === 1'b1)
		begin
			e = exp_q.pop_front();
			chk(pslverr, e[32]);
			if (!pwrite) chk(prdata, e[31:0]);
		end

	// Watchdog, far beyond the under a thousand cycles the run needs
	initial
	begin
		#100000;
		num_errors++;
		close_out();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		{clk, rstn, psel, penable, pwrite, link_up_pin, eeprom_addr_load} = '0;
		{paddr, pwdata, eeprom_addr, num_errors, num_checks} = '0;
		bus_reset_n = 1'b1;
		seed = 32'ha3f5_ef6a;
		node = 48'h6655_4433_2211;
		cyc(3);
		rstn <= 1'b1;
		cyc(1);
		chk({inta_n, power_event_pin_n, external_start_n, network_wake_out}, 4'b1110);
		rd(`OFF_PM_CTRL, 32'h0000_0000);
		@(posedge clk);
		eeprom_addr_load <= 1'b1;
		eeprom_addr <= node;
		@(posedge clk);
		eeprom_addr_load <= 1'b0;
		rd(`OFF_ADDR_LOW, node[31:0]);
		rd(`OFF_ADDR_HIGH, {16'h0000, node[47:32]});
		m = nxt();
		wr(`OFF_MASK1, m);
		rd(`OFF_MASK1, m);
		apb(1'b0, 12'hFFC, 32'h0000_0000, 33'h1_0000_0000);
		// Enabled but fully on: a pattern must be ignored and frames stored
		wr(`OFF_PM_CTRL, 32'h0000_0100);
		pattern_frame();
		src.send(fr, 1'b1, 1'b1, 1'b0);
		cyc(5);
		rd(`OFF_PM_CTRL, 32'h0000_0100);
		chk(rx_store_en, 1'b1);
		wr(`OFF_PM_CTRL, 32'h0000_0101);
		cyc(2);
		chk(rx_store_en, 1'b0);
		// Pattern with a bad frame CRC, sent slowly, still wakes
		src.send(fr, 1'b1, 1'b0, 1'b1);
		cyc(5);
		rd(`OFF_PM_CTRL, 32'h0000_8101);
		rd(`OFF_INT_STATUS, 32'h1000_0000);
		chk({inta_n, power_event_pin_n}, 2'b00);
		chk({external_start_n, network_wake_out}, 2'b01);
		wr(`OFF_PM_CTRL, 32'h0000_8101);
		wr(`OFF_INT_STATUS, 32'h1000_0000);
		cyc(3);
		chk({inta_n, power_event_pin_n, network_wake_out}, 3'b111);
		@(posedge clk);
		bus_reset_n <= 1'b0;
		cyc(6);
		chk({external_start_n, network_wake_out}, 2'b10);
		bus_reset_n <= 1'b1;
		// Pattern to another station is not a wake
		pattern_frame();
		src.send(fr, 1'b0, 1'b1, 1'b0);
		cyc(5);
		rd(`OFF_PM_CTRL, 32'h0000_0101);
		// Filters 0 and 3 both check byte 13 of a random frame
		fr = {};
		for (int i = 0; i < 20; i++) fr.push_back(8'(nxt()));
		crc_ref = crc_byte(`CRC_INIT, fr[13]);
		wr(`OFF_FILT_OFS, 32'h8D00_008D);
		wr(`OFF_CRC01, {16'h0000, crc_ref});
		wr(`OFF_CRC23, {crc_ref, 16'h0000});
		wr(`OFF_MASK0, 32'h0000_0001);
		wr(`OFF_MASK3, 32'h0000_0001);
		src.send(fr, 1'b1, 1'b0, 1'b1);
		cyc(5);
		rd(`OFF_PM_CTRL, 32'h0000_0101);
		// Chain selects 00..11, then chaining off; only F0 and F3 hit
		for (int i = 0; i < 5; i++)
		begin
			wr(`OFF_ROM_CTRL, i[1:0] << `CHAIN_SEL_LSB);
			wr(`OFF_FLOW_CHAIN, (i < 4) ? 32'h0000_0010 : 32'h0000_0000);
			src.send(fr, 1'b1, 1'b1, 1'b1);
			cyc(5);
			rd(`OFF_PM_CTRL, 5'b10110 >> i & 1 ? 32'h0000_8101 : 32'h0000_0101);
			wr(`OFF_PM_CTRL, 32'h0000_8101);
		end
		wr(`OFF_FILT_OFS, 32'h0D00_000D);
		src.send(fr, 1'b1, 1'b1, 1'b0);
		cyc(5);
		rd(`OFF_PM_CTRL, 32'h0000_0101);
		// Cable event while asleep
		link_up_pin <= 1'b1;
		cyc(8);
		rd(`OFF_PM_CTRL, 32'h0000_8101);
		close_out();
	end
endmodule : network_wake_event_detector_tb

// *** bench/rx_frame_source.sv ***
// Receive-path model that feeds frames to the wake block one byte a beat
`timescale 1ns/1ps
module rx_frame_source (
	input  wire logic          clk,
	output wake_pkg::rx_beat_t rx_beat
);
	// ==========================================
	// Frame sender
	// Idle data is inverted once per stall and after eof, with valid low, so a stale byte never looks valid
	initial
	begin
		rx_beat = '0;
	end
	// Slow mode stalls one beat between bytes; verdict bits ride on eof only
	task automatic send(input logic [7:0] fr[$], input logic da, input logic ok, input logic slow);
		for (int i = 0; i < fr.size(); i++)
		begin
			if (slow && i > 0)
			begin
				@(posedge clk);
				rx_beat <= {5'b0_0000, ~rx_beat.data};
			end
			@(posedge clk);
			rx_beat.valid    <= 1'b1;
			rx_beat.sof      <= (i == 0);
			rx_beat.eof      <= (i == fr.size() - 1);
			rx_beat.da_match <= da && (i == fr.size() - 1);
			rx_beat.crc_ok   <= ok && (i == fr.size() - 1);
			rx_beat.data     <= fr[i];
		end
		@(posedge clk);
		rx_beat <= {5'b0_0000, ~rx_beat.data};
	endtask : send
endmodule : rx_frame_source

// *** logic/wake_crc_filter.sv ***
// One wake filter: CRC-16 over masked frame bytes
`timescale 1ns/1ps
`include "wake_regs.svh"
module wake_crc_filter #(
	parameter int MASK_BITS = 32
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire wake_pkg::rx_beat_t    beat,
	input  wire logic [7:0]            pos,
	input  wire logic [6:0]            offset,
	input  wire logic [MASK_BITS-1:0]  mask,
	output logic [15:0]                crc_reg
);
	localparam int IW = $clog2(MASK_BITS);
	if (MASK_BITS < 2 || MASK_BITS > 128 || (1 << IW) != MASK_BITS)
		$error("MASK_BITS must be a power of two up to 128");

	// ==========================================
	// CRC step, bits taken least significant first as on the wire
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0};
			if (fb)
				r = r ^ `CRC_POLY;
		end
		return r;
	endfunction : crc16_byte

	logic [7:0] rel;
	logic       hit;
	// Byte offset+j joins the check when mask bit j is set
	assign rel = pos - {1'b0, offset};
	assign hit = beat.valid && (pos >= {1'b0, offset}) && (rel < 8'(MASK_BITS))
		&& mask[rel[IW-1:0]];

	// Restart at each frame so the remainder belongs to one frame only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			crc_reg <= `CRC_INIT;
		else if (beat.valid && beat.sof)
			crc_reg <= hit ? crc16_byte(`CRC_INIT, beat.data) : `CRC_INIT;
		else if (hit)
			crc_reg <= crc16_byte(crc_reg, beat.data);
	end
endmodule : wake_crc_filter

// *** logic/wake_event_detector.sv ***
// Top of the wake event logic: APB registers, frame tracking, wake outputs
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "wake_regs.svh"
// Function
// - Mask bit j set puts frame byte offset+j into that filter's check.
// - Each filter's 7-bit offset sits in its own byte of the offset register.
// - A filter joins wake checking only while its enable bit is set.
// - CRC-16 of selected bytes equal to the reference value means a filter hit.
// - The filter CRC uses x^16 + x^15 + x^2 + 1.
// - Chain enable bit 4; while clear any single filter hit counts.
// - Chain select picks one of four AND/OR combinations of filter hits.
// - Frame wake also needs sleep, address match, good frame CRC, event enable.
// - Node wake address loads from the serial EEPROM without software.
// - Receive scanning keeps running in every sleep state.
// - Wake sources: wake pattern, wake frame, link state change.
// - Any wake event sets the PME status bit 15.
// - Any wake event drives the interrupt pin and power event pin low.
// - Any wake event outside bus reset asserts external start and network wake outputs.
// - Bus reset deasserts the network wake output.
// - Pattern is six 0xFF bytes then sixteen address copies, anywhere.
// - The pattern scanner is idle in D0.
// - While asleep, received frames are not stored in the receive FIFO.
// - Pattern wake needs address match, enable, sleep; frame CRC ignored.
module network_wake_event_detector (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire wake_pkg::rx_beat_t  rx_beat,
	input  wire logic                link_up_pin,
	input  wire logic                bus_reset_n,
	input  wire logic                eeprom_addr_load,
	input  wire logic [47:0]         eeprom_addr,
	output logic                     inta_n,
	output logic                     power_event_pin_n,
	output logic                     external_start_n,
	output logic                     network_wake_out,
	output logic                     rx_store_en
);
	// ==========================================
	// Register state
	wake_pkg::power_state_t pm_state_reg;
	logic        pme_en_reg;
	logic        pme_sts_reg;
	logic        wake_int_reg;
	logic [1:0]  chain_sel_reg;
	logic        chain_en_reg;
	logic [47:0] node_addr_reg;
	logic [31:0] mask_reg [4];
	logic [31:0] filt_ofs_reg;
	logic [31:0] crc01_reg;
	logic [31:0] crc23_reg;

	logic        wr_en;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic        asleep;

	assign wr_en  = psel && penable && pready && pwrite;
	assign asleep = pm_state_reg != wake_pkg::PS_D0;

	// ==========================================
	// Pin synchronisers
	logic link_meta;
	logic link_sync;
	logic link_prev;
	logic brst_meta;
	logic brst_sync;

	// Link status and bus reset come from pins, so two flops each
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			link_meta <= 1'b0;
			link_sync <= 1'b0;
			link_prev <= 1'b0;
			brst_meta <= 1'b0;
			brst_sync <= 1'b0;
		end
		else
		begin
			link_meta <= link_up_pin;
			link_sync <= link_meta;
			link_prev <= link_sync;
			brst_meta <= bus_reset_n;
			brst_sync <= brst_meta;
		end
	end

	// ==========================================
	// APB slave: answers in the first access cycle
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_word = `RST_WORD;
		unique case (paddr)
			`OFF_PM_CTRL:
			begin
				rd_word[`PM_STATE_MSB:`PM_STATE_LSB] = pm_state_reg;
				rd_word[`PM_EN_BIT]  = pme_en_reg;
				rd_word[`PM_STS_BIT] = pme_sts_reg;
			end
			`OFF_INT_STATUS: rd_word[`INT_WAKE_BIT] = wake_int_reg;
			`OFF_ROM_CTRL:   rd_word[`CHAIN_SEL_MSB:`CHAIN_SEL_LSB] = chain_sel_reg;
			`OFF_FLOW_CHAIN: rd_word[`CHAIN_EN_BIT] = chain_en_reg;
			`OFF_ADDR_HIGH:  rd_word[15:0] = node_addr_reg[47:32];
			`OFF_ADDR_LOW:   rd_word = node_addr_reg[31:0];
			`OFF_MASK0:      rd_word = mask_reg[0];
			`OFF_MASK1:      rd_word = mask_reg[1];
			`OFF_MASK2:      rd_word = mask_reg[2];
			`OFF_MASK3:      rd_word = mask_reg[3];
			`OFF_FILT_OFS:   rd_word = filt_ofs_reg;
			`OFF_CRC01:      rd_word = crc01_reg;
			`OFF_CRC23:      rd_word = crc23_reg;
			default:         rd_hit = 1'b0;
		endcase
	end

	// Ready in the access phase only; unmapped addresses answer with an error
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `RST_WORD;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			prdata  <= (psel && !penable && !pwrite) ? rd_word : `RST_WORD;
		end
	end

	// ==========================================
	// Plain read/write configuration
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pm_state_reg  <= wake_pkg::PS_D0;
			pme_en_reg    <= 1'b0;
			chain_sel_reg <= 2'h0;
			chain_en_reg  <= 1'b0;
			filt_ofs_reg  <= `RST_WORD;
			crc01_reg     <= `RST_WORD;
			crc23_reg     <= `RST_WORD;
			for (int i = 0; i < 4; i++)
				mask_reg[i] <= `RST_WORD;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				`OFF_PM_CTRL:
				begin
					pm_state_reg <= wake_pkg::power_state_t'(
						pwdata[`PM_STATE_MSB:`PM_STATE_LSB]);
					pme_en_reg   <= pwdata[`PM_EN_BIT];
				end
				`OFF_ROM_CTRL:   chain_sel_reg <= pwdata[`CHAIN_SEL_MSB:`CHAIN_SEL_LSB];
				`OFF_FLOW_CHAIN: chain_en_reg  <= pwdata[`CHAIN_EN_BIT];
				`OFF_MASK0:      mask_reg[0]   <= pwdata;
				`OFF_MASK1:      mask_reg[1]   <= pwdata;
				`OFF_MASK2:      mask_reg[2]   <= pwdata;
				`OFF_MASK3:      mask_reg[3]   <= pwdata;
				`OFF_FILT_OFS:   filt_ofs_reg  <= pwdata;
				`OFF_CRC01:      crc01_reg     <= pwdata;
				`OFF_CRC23:      crc23_reg     <= pwdata;
				default:         ;
			endcase
		end
	end

	// Node address: the EEPROM loader fills it at power-up, software may override
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			node_addr_reg <= `RST_ADDR;
		else if (eeprom_addr_load)
			node_addr_reg <= eeprom_addr;
		else if (wr_en && paddr == `OFF_ADDR_HIGH)
			node_addr_reg[47:32] <= pwdata[15:0];
		else if (wr_en && paddr == `OFF_ADDR_LOW)
			node_addr_reg[31:0] <= pwdata;
	end

	// ==========================================
	// Frame position and end-of-frame verdicts
	logic [7:0] pos_cnt;
	logic [7:0] pos;
	logic       frame_end_reg;
	logic       da_reg;
	logic       crc_ok_reg;

	// Position zero is the first destination address byte
	assign pos = rx_beat.sof ? 8'h00 : pos_cnt;

	// Verdicts are judged one cycle after the last byte, once the CRCs settle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pos_cnt       <= 8'h00;
			frame_end_reg <= 1'b0;
			da_reg        <= 1'b0;
			crc_ok_reg    <= 1'b0;
		end
		else
		begin
			frame_end_reg <= rx_beat.valid && rx_beat.eof;
			if (rx_beat.valid)
				pos_cnt <= (pos == `POS_MAX) ? pos : pos + 8'h01;
			if (rx_beat.valid && rx_beat.eof)
			begin
				da_reg     <= rx_beat.da_match;
				crc_ok_reg <= rx_beat.crc_ok;
			end
		end
	end

	// ==========================================
	// Four wake filters and the pattern scanner
	logic [15:0] filt_crc [4];
	logic [3:0]  filt_hit;
	logic        pattern_seen;

	for (genvar g = 0; g < 4; g++)
	begin : gen_filter
		wake_crc_filter #(
			.MASK_BITS (32)
		) u_filter (
			.clk     (clk),
			.rstn    (rstn),
			.beat    (rx_beat),
			.pos     (pos),
			.offset  (filt_ofs_reg[g*`FILT_FIELD_W +: 7]),
			.mask    (mask_reg[g]),
			.crc_reg (filt_crc[g])
		);
		// Disabled filters never hit
		assign filt_hit[g] = filt_ofs_reg[g*`FILT_FIELD_W + `FILT_EN_POS]
			&& filt_crc[g] == (g < 2 ? crc01_reg[(g % 2)*`CRC_FIELD_W +: 16]
			: crc23_reg[(g % 2)*`CRC_FIELD_W +: 16]);
	end

	// Scanner runs only while asleep; receive logic stays alive in every sleep state
	wake_pattern_scan u_scan (
		.clk       (clk),
		.rstn      (rstn),
		.beat      (rx_beat),
		.enable    (asleep),
		.node_addr (node_addr_reg),
		.seen_reg  (pattern_seen)
	);

	// Combine filter hits, chained or independent
	function automatic logic chain_cond(input logic [3:0] h, input logic en,
		input logic [1:0] sel);
		if (!en)
			return |h;
		unique case (sel)
			2'h0: return (h[0] & h[1]) | (h[2] & h[3]);
			2'h1: return (h[0] & h[1]) | h[2] | h[3];
			2'h2: return (h[0] & h[1] & h[2]) | h[3];
			2'h3: return &h;
		endcase
	endfunction : chain_cond

	// ==========================================
	// Wake sources
	logic frame_ok;
	logic frame_wake;
	logic pattern_wake;
	logic link_wake;
	logic wake_event;

	assign frame_ok     = frame_end_reg && asleep && pme_en_reg && da_reg;
	assign frame_wake   = frame_ok && crc_ok_reg
		&& chain_cond(filt_hit, chain_en_reg, chain_sel_reg);
	assign pattern_wake = frame_ok && pattern_seen;
	assign link_wake    = asleep && pme_en_reg && (link_sync != link_prev);
	assign wake_event   = frame_wake || pattern_wake || link_wake;

	// Sticky status: a wake in the clearing cycle wins over the clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pme_sts_reg  <= 1'b0;
			wake_int_reg <= 1'b0;
		end
		else
		begin
			if (wake_event)
				pme_sts_reg <= 1'b1;
			else if (wr_en && paddr == `OFF_PM_CTRL && pwdata[`PM_STS_BIT])
				pme_sts_reg <= 1'b0;
			if (wake_event)
				wake_int_reg <= 1'b1;
			else if (wr_en && paddr == `OFF_INT_STATUS && pwdata[`INT_WAKE_BIT])
				wake_int_reg <= 1'b0;
		end
	end

	// ==========================================
	// Output pins, all from flops
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			inta_n            <= 1'b1;
			power_event_pin_n <= 1'b1;
			rx_store_en       <= 1'b1;
		end
		else
		begin
			inta_n            <= !wake_int_reg;
			power_event_pin_n <= !(pme_sts_reg && pme_en_reg);
			rx_store_en       <= !asleep;
		end
	end

	// Wake outputs latch until the bus reset, which also wins over a wake in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			network_wake_out <= 1'b0;
			external_start_n <= 1'b1;
		end
		else if (!brst_sync)
		begin
			network_wake_out <= 1'b0;
			external_start_n <= 1'b1;
		end
		else if (wake_event)
		begin
			network_wake_out <= 1'b1;
			external_start_n <= 1'b0;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_frame_close;
		frame_end_reg && asleep && pme_en_reg && da_reg;
	endsequence
	sequence s_pin_path;
		wake_event ##2 (!inta_n && !power_event_pin_n);
	endsequence

	a_pme_status_set: assert property (
		wake_event |=> pme_sts_reg) else $error("PME status not set on wake");
	a_wake_flag_set: assert property (
		wake_event |=> wake_int_reg) else $error("Wake flag not set on wake");
	a_wake_pins_low: assert property (
		wake_event |-> s_pin_path) else $error("Interrupt or event pin not low");
	a_wake_outputs_on: assert property (
		wake_event && brst_sync |=> network_wake_out && !external_start_n)
		else $error("Wake outputs not asserted");
	a_bus_reset_clears: assert property (
		!brst_sync |=> !network_wake_out) else $error("Wake output survived bus reset");
	a_d0_no_wake: assert property (
		!asleep |-> !wake_event) else $error("Wake event while in D0");
	a_sleep_no_store: assert property (
		asleep [*2] |-> !rx_store_en) else $error("Frames stored while asleep");
	a_chain_off_any: assert property (
		s_frame_close ##0 (crc_ok_reg && !chain_en_reg && |filt_hit) |-> wake_event)
		else $error("Independent filter hit ignored");
	a_frame_crc_need: assert property (
		frame_wake |-> crc_ok_reg && da_reg) else $error("Frame wake without good CRC");
	a_filter_enabled: assert property (
		frame_wake |-> |(filt_hit)) else $error("Frame wake without enabled filter");
endmodule : network_wake_event_detector

// *** logic/wake_pattern_scan.sv ***
// Remote wake pattern scanner: sync run then repeated node address
`timescale 1ns/1ps
`include "wake_regs.svh"
module wake_pattern_scan (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire wake_pkg::rx_beat_t  beat,
	input  wire logic                enable,
	input  wire logic [47:0]         node_addr,
	output logic                     seen_reg
);
	logic [2:0] sync_cnt;
	logic [2:0] byte_idx;
	logic [4:0] rep_cnt;
	logic       in_run;
	logic       take;
	logic [7:0] expect_byte;

	assign in_run      = (byte_idx != 3'h0) || (rep_cnt != 5'h00);
	assign expect_byte = node_addr[{byte_idx, 3'h0} +: 8];
	// Pattern may start anywhere; a broken address run aborts the match
	assign take = (in_run || sync_cnt == `SYNC_FULL) && beat.data == expect_byte;

	// ==========================================
	// Scan only while enabled; frame start clears the verdict
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_cnt <= 3'h0;
			byte_idx <= 3'h0;
			rep_cnt  <= 5'h00;
			seen_reg <= 1'b0;
		end
		else if (!enable || (beat.valid && beat.sof))
		begin
			sync_cnt <= (enable && beat.data == `SYNC_BYTE) ? 3'h1 : 3'h0;
			byte_idx <= 3'h0;
			rep_cnt  <= 5'h00;
			seen_reg <= 1'b0;
		end
		else if (beat.valid)
		begin
			if (take)
			begin
				sync_cnt <= 3'h0;
				byte_idx <= (byte_idx == `ADDR_LAST) ? 3'h0 : byte_idx + 3'h1;
				if (byte_idx == `ADDR_LAST)
					rep_cnt <= (rep_cnt == `REPS_LAST) ? 5'h00 : rep_cnt + 5'h01;
				if (byte_idx == `ADDR_LAST && rep_cnt == `REPS_LAST)
					seen_reg <= 1'b1;
			end
			else
			begin
				// Extra sync bytes keep the count saturated
				sync_cnt <= (beat.data != `SYNC_BYTE) ? 3'h0 :
					(sync_cnt == `SYNC_FULL) ? sync_cnt : sync_cnt + 3'h1;
				byte_idx <= 3'h0;
				rep_cnt  <= 5'h00;
			end
		end
	end
endmodule : wake_pattern_scan

// *** logic/wake_pkg.sv ***
// Types shared by the wake event logic
package wake_pkg;
	// Power state field, D0 first
	typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3HOT} power_state_t;
	// One received byte with its framing and address-filter verdicts
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       da_match;
		logic       crc_ok;
		logic [7:0] data;
	} rx_beat_t;
endpackage : wake_pkg

// *** logic/wake_regs.svh ***
// Register offsets, field positions, reset values and counts of the wake block
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH
// ==========================================
// Register byte offsets
`define OFF_PM_CTRL      12'h000
`define OFF_INT_STATUS   12'h004
`define OFF_ROM_CTRL     12'h008
`define OFF_FLOW_CHAIN   12'h00C
`define OFF_ADDR_HIGH    12'h010
`define OFF_ADDR_LOW     12'h014
`define OFF_MASK0        12'h018
`define OFF_MASK1        12'h01C
`define OFF_MASK2        12'h020
`define OFF_MASK3        12'h024
`define OFF_FILT_OFS     12'h028
`define OFF_CRC01        12'h02C
`define OFF_CRC23        12'h030
// ==========================================
// Field positions
`define PM_STATE_MSB     1
`define PM_STATE_LSB     0
`define PM_EN_BIT        8
`define PM_STS_BIT       15
`define INT_WAKE_BIT     28
`define CHAIN_SEL_MSB    26
`define CHAIN_SEL_LSB    25
`define CHAIN_EN_BIT     4
`define FILT_FIELD_W     8
`define FILT_EN_POS      7
`define CRC_FIELD_W      16
// ==========================================
// Reset values and constants
`define RST_WORD         32'h0000_0000
`define RST_ADDR         48'h0000_0000_0000
`define CRC_INIT         16'hFFFF
`define CRC_POLY         16'h8005
`define SYNC_BYTE        8'hFF
`define SYNC_FULL        3'h6
`define ADDR_LAST        3'h5
`define REPS_LAST        5'h0F
`define POS_MAX          8'hFF
`endif
